// File: bench/rmpsel_pins.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module rmpsel_pins (
	input  wire logic        CLK,
	input  wire logic [25:0] PIN_OUT,
	input  wire logic [25:0] PIN_OE_N,
	input  wire logic [25:0] PIN_PULLUP_EN,
	input  wire logic [25:0] EXT_VAL,
	input  wire logic [25:0] EXT_EN,
	output wire logic [25:0] PIN_IN
);
	logic [25:0] float_r = 26'h0000000;

	// undriven pins without a pull-up toggle so a stale level can never pass for a real one
	always @(posedge CLK)
		float_r <= ~PIN_IN;

	// the device driver wins over the outside source
	// a released pin that the outside source leaves undriven rises through its weak pull-up
	assign PIN_IN = (~PIN_OE_N & PIN_OUT) | (PIN_OE_N & EXT_EN & EXT_VAL)
		| (PIN_OE_N & ~EXT_EN & (PIN_PULLUP_EN | float_r));
endmodule

// File: bench/rmpsel_props.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module rmpsel_props (
	input wire        CLK,
	input wire        RST_N,
	input wire        S_AXI_AWREADY,
	input wire        S_AXI_WREADY,
	input wire [1:0]  S_AXI_BRESP,
	input wire        S_AXI_BVALID,
	input wire        S_AXI_BREADY,
	input wire        S_AXI_ARREADY,
	input wire [31:0] S_AXI_RDATA,
	input wire        S_AXI_RVALID,
	input wire        S_AXI_RREADY,
	input wire [25:0] PIN_OE_N,
	input wire [25:0] PIN_PULLUP_EN,
	input wire [25:0] PIN_DIG_BUF_EN,
	input wire        EXT_IRQ_1,
	input wire        EXT_IRQ_2,
	input wire        TIMER2_EXT_CLOCK,
	input wire        TIMER3_EXT_CLOCK,
	input wire        CAPTURE_INPUT_1,
	input wire        CAPTURE_INPUT_2,
	input wire        CFG_MISMATCH_RST
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	wire per_any = EXT_IRQ_1 | EXT_IRQ_2 | TIMER2_EXT_CLOCK | TIMER3_EXT_CLOCK | CAPTURE_INPUT_1 | CAPTURE_INPUT_2;

	a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped early");
	a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped early");
	a_write_answer: assert property (S_AXI_AWREADY && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
		else $error("write not answered");
	a_read_answer: assert property (S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read not answered");
	a_busy_refuse: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write taken while response pending");
	a_reset_state: assert property ($rose(RST_N) |-> PIN_OE_N == 26'h3FFFFFF && PIN_DIG_BUF_EN == 26'h0)
		else $error("pins not analog inputs after reset");
	a_analog_quiet: assert property (PIN_DIG_BUF_EN == 26'h0 [*6] |-> !per_any)
		else $error("peripheral input high with all pins analog");
	a_pullup_prio: assert property ((PIN_PULLUP_EN & ~PIN_DIG_BUF_EN) == 26'h0)
		else $error("pull-up on an analog pin");
	a_mismatch_sticky: assert property (CFG_MISMATCH_RST |=> CFG_MISMATCH_RST)
		else $error("mismatch reset request dropped");

	cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h2);
	cover property (EXT_IRQ_1 && TIMER3_EXT_CLOCK && CAPTURE_INPUT_2);
	cover property (!PIN_OE_N[3] && !PIN_DIG_BUF_EN[3]);
endmodule

bind rmpsel_top rmpsel_props u_props (.CLK(CLK), .RST_N(RST_N), .S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
	.S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .PIN_OE_N(PIN_OE_N),
	.PIN_PULLUP_EN(PIN_PULLUP_EN), .PIN_DIG_BUF_EN(PIN_DIG_BUF_EN), .EXT_IRQ_1(EXT_IRQ_1),
	.EXT_IRQ_2(EXT_IRQ_2), .TIMER2_EXT_CLOCK(TIMER2_EXT_CLOCK), .TIMER3_EXT_CLOCK(TIMER3_EXT_CLOCK),
	.CAPTURE_INPUT_1(CAPTURE_INPUT_1), .CAPTURE_INPUT_2(CAPTURE_INPUT_2), .CFG_MISMATCH_RST(CFG_MISMATCH_RST));

// File: bench/testbench.sv
`timescale 1ns/100ps
`include "rmpsel_consts.vh"
////////////////////////////////////////////////////////////////////////////////
module testbench;
	logic        clk = 1'b0, rst_n = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, irq1, irq2, t2, t3, c1, c2, mism;
	logic [1:0]  bresp, rresp;
	logic [25:0] pin_in, pin_out, oe_n, pu_en, dbuf, ext_val = 26'h2AAAAAA;
	logic [4:0]  s;
	logic [3:0]  wstrb = 4'hF;
	int          mismatches = 0, n_compared = 0;

	always #2 clk = ~clk;

	rmpsel_top dut_u (.CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PIN_IN(pin_in),
		.PIN_OUT(pin_out), .PIN_OE_N(oe_n), .PIN_PULLUP_EN(pu_en), .PIN_DIG_BUF_EN(dbuf),
		.EXT_IRQ_1(irq1), .EXT_IRQ_2(irq2), .TIMER2_EXT_CLOCK(t2), .TIMER3_EXT_CLOCK(t3),
		.CAPTURE_INPUT_1(c1), .CAPTURE_INPUT_2(c2), .CFG_MISMATCH_RST(mism));
	rmpsel_pins pins_u (.CLK(clk), .PIN_OUT(pin_out), .PIN_OE_N(oe_n), .PIN_PULLUP_EN(pu_en),
		.EXT_VAL(ext_val), .EXT_EN(26'h3FFFFFF), .PIN_IN(pin_in));

	task summarize;
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task bound(input int i);
		if (i >= 100) begin
			mismatches++;
			summarize();
		end
	endtask

	// both channels offered together; bready stays up until the answer is sampled
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int i;
		logic aw, w;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw = 1'b0;
		w = 1'b0;
		i = 0;
		while (!(aw && w) && i < 100) begin
			@(posedge clk);
			if (awready) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
			i++;
		end
		do begin
			@(posedge clk);
			i++;
		end while (bvalid !== 1'b1 && i < 100);
		bound(i);
		chk(bresp, er);
		bready <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int i;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		i = 0;
		do begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
			i++;
		end while (rvalid !== 1'b1 && i < 100);
		bound(i);
		chk(rdata, ed);
		chk(rresp, er);
		rready <= 1'b0;
	endtask

	function automatic logic e(input logic [4:0] k);
		return (k < 5'd26) ? ext_val[k] : 1'b0;
	endfunction

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rd(`RMPSEL_OFF_IRQ1, 32'h1F00, 2'h0);
		rd(`RMPSEL_OFF_IRQ2, 32'h001F, 2'h0);
		rd(`RMPSEL_OFF_CAPT, 32'h1F1F, 2'h0);
		rd(`RMPSEL_OFF_ANCFG0, 32'h0, 2'h0);
		chk({irq1, irq2, t2, t3, c1, c2, dbuf}, 32'h0);
		$display("reset test done");
		wr(`RMPSEL_OFF_ANCFG0, 32'h3FFFFFF, 2'h0);
		wr(`RMPSEL_OFF_ANCFG1, 32'h3FFFFFF, 2'h0);
		for (int j = 0; j < 16; j++) begin
			s = (j < 8) ? 5'(j * 4 + 1) : 5'(j + 16);
			ext_val <= j[0] ? 26'h1555555 : 26'h2AAAAAA;
			wr(`RMPSEL_OFF_IRQ1, 32'hFFFFE0E0 | {s, 8'h00}, 2'h0);
			wr(`RMPSEL_OFF_IRQ2, 32'hFFFFE0E0 | (s ^ 5'h01), 2'h0);
			wr(`RMPSEL_OFF_TMRCLK, 32'hFFFFE0E0 | {s, 3'h0, s ^ 5'h01}, 2'h0);
			wr(`RMPSEL_OFF_CAPT, 32'hFFFFE0E0 | {s, 3'h0, s ^ 5'h01}, 2'h0);
			repeat (4) @(posedge clk);
			chk({irq1, t3, c2}, {3{e(s)}});
			chk({irq2, t2, c1}, {3{e(s ^ 5'h01)}});
			rd(`RMPSEL_OFF_TMRCLK, {s, 3'h0, s ^ 5'h01}, 2'h0);
			rd(`RMPSEL_OFF_IRQ1, {s, 8'h00}, 2'h0);
		end
		$display("routing test done");
		ext_val <= 26'h0000008;
		wr(`RMPSEL_OFF_IRQ1, 32'h0300, 2'h0);
		wr(`RMPSEL_OFF_ANCFG1, 32'h3FFFFF7, 2'h0);
		repeat (4) @(posedge clk);
		chk({irq1, dbuf}, 27'h3FFFFF7);
		rd(`RMPSEL_OFF_PINRD, 32'h0, 2'h0);
		wr(`RMPSEL_OFF_ANCFG1, 32'h3FFFFFF, 2'h0);
		wr(`RMPSEL_OFF_ANCFG0, 32'h3FFFFF7, 2'h0);
		wr(`RMPSEL_OFF_PULLUP, 32'h3FFFFFF, 2'h0);
		repeat (4) @(posedge clk);
		chk({irq1, pu_en}, 27'h3FFFFF7);
		wr(`RMPSEL_OFF_DIR, 32'h0, 2'h0);
		wr(`RMPSEL_OFF_LATCH, 32'h8, 2'h0);
		repeat (2) @(posedge clk);
		chk(oe_n, 32'h0);
		chk(pin_out, 32'h8);
		wr(`RMPSEL_OFF_DIR, 32'h3FFFFFF, 2'h0);
		wr(`RMPSEL_OFF_ANCFG0, 32'h3FFFFFF, 2'h0);
		repeat (4) @(posedge clk);
		chk(irq1, 1'b1);
		rd(`RMPSEL_OFF_PINRD, 32'h8, 2'h0);
		$display("analog test done");
		wr(`RMPSEL_OFF_OSCCTL, 32'h46, 2'h0);
		wr(`RMPSEL_OFF_OSCCTL, 32'h57, 2'h0);
		wr(`RMPSEL_OFF_OSCCTL, 32'h40, 2'h0);
		rd(`RMPSEL_OFF_OSCCTL, 32'h40, 2'h0);
		wr(`RMPSEL_OFF_IRQ2, 32'h5, 2'h0);
		rd(`RMPSEL_OFF_IRQ2, 32'h1E, 2'h0);
		wr(`RMPSEL_OFF_OSCCTL, 32'h46, 2'h0);
		wr(`RMPSEL_OFF_OSCCTL, 32'h57, 2'h0);
		wr(`RMPSEL_OFF_OSCCTL, 32'h00, 2'h0);
		wr(`RMPSEL_OFF_IRQ2, 32'h5, 2'h0);
		rd(`RMPSEL_OFF_IRQ2, 32'h5, 2'h0);
		wstrb <= 4'h2;
		wr(`RMPSEL_OFF_CAPT, 32'h0, 2'h0);
		wstrb <= 4'hF;
		rd(`RMPSEL_OFF_CAPT, 32'h001E, 2'h0);
		wr(8'h30, 32'h1, 2'h2);
		rd(8'h30, 32'h0, 2'h2);
		chk(mism, 1'b0);
		rd(`RMPSEL_OFF_STAT, 32'h0, 2'h0);
		$display("lock test done");
		wr(`RMPSEL_OFF_ANCFG0, 32'h0, 2'h0);
		repeat (8) @(posedge clk);
		chk({irq1, dbuf}, 32'h0);
		rd(`RMPSEL_OFF_PINRD, 32'h0, 2'h0);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd(`RMPSEL_OFF_OSCCTL, 32'h0, 2'h0);
		rd(`RMPSEL_OFF_ANCFG0, 32'h0, 2'h0);
		rd(`RMPSEL_OFF_IRQ1, 32'h1F00, 2'h0);
		chk({irq1, irq2, t2, t3, c1, c2, dbuf}, 32'h0);
		$display("second reset test done");
		summarize();
	end
endmodule

// File: design/rmpsel_consts.vh
`ifndef RMPSEL_CONSTS_VH
`define RMPSEL_CONSTS_VH

// register byte offsets
`define RMPSEL_OFF_IRQ1      8'h00
`define RMPSEL_OFF_IRQ2      8'h04
`define RMPSEL_OFF_TMRCLK    8'h08
`define RMPSEL_OFF_CAPT      8'h0C
`define RMPSEL_OFF_OSCCTL    8'h10
`define RMPSEL_OFF_ANCFG0    8'h14
`define RMPSEL_OFF_ANCFG1    8'h18
`define RMPSEL_OFF_DIR       8'h1C
`define RMPSEL_OFF_PULLUP    8'h20
`define RMPSEL_OFF_LATCH     8'h24
`define RMPSEL_OFF_PINRD     8'h28
`define RMPSEL_OFF_STAT      8'h2C

// selector field positions
`define RMPSEL_HI_LSB        8
`define RMPSEL_LO_LSB        0
`define RMPSEL_SEL_W         5
`define RMPSEL_SEL_RST       5'h1F
`define RMPSEL_SEL_MAXPIN    5'h19

// oscillator control: lock bit and key bytes
`define RMPSEL_LOCK_BIT      6
`define RMPSEL_KEY1          8'h46
`define RMPSEL_KEY2          8'h57

`define RMPSEL_NPIN          26
`define RMPSEL_ANCFG_RST     26'h0000000
`define RMPSEL_DIR_RST       26'h3FFFFFF

`define RMPSEL_RESP_OKAY     2'h0
`define RMPSEL_RESP_SLVERR   2'h2

`endif

// File: design/rmpsel_top.v
// What this block does
// RULE1 - shared analog pins come up analog after every reset
// RULE2 - analog pin: digital input buffer off, digital read returns zero
// RULE3 - writing one to a pin's converter config bit makes it digital
// RULE4 - pin is digital only when both converters' config bits select digital
// RULE5 - output driver still works on an analog pin set to output
// RULE6 - only highest-priority enabled function controls a pin
// RULE7 - each change-notify pin has a software-switchable weak pull-up
// RULE8 - remap configuration is nine input and eight output registers; this block holds four input ones and no output ones
// RULE9 - selection registers change only while the lock bit is zero
// RULE10 - selector values 0..25 route that pin, 31 drives low
// RULE11 - irq1 selector sits in bits 12..8 of input register 0
// RULE12 - irq2 selector sits in bits 4..0 of input register 1
// RULE13 - timer3 clock selector sits in bits 12..8 of register 3
// RULE14 - timer2 clock selector sits in bits 4..0 of register 3
// RULE15 - capture2 selector sits in bits 12..8 of register 7
// RULE16 - capture1 selector sits in bits 4..0 of register 7
// RULE17 - every implemented selector bit resets to one, inputs tied low
// RULE18 - unimplemented bits ignore writes and read as zero
// RULE19 - locked writes complete without error, contents unchanged
// RULE20 - software writes 0x46 then 0x57 before changing the lock bit
// RULE21 - software sets pin direction to input when remapping an input
// RULE22 - shadow copies watch selectors; any mismatch raises a reset request
// RULE23 - selector values 26..30 drive the peripheral input low
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "rmpsel_consts.vh"

module rmpsel_top (
	input  wire        CLK,
	input  wire        RST_N,
	input  wire [7:0]  S_AXI_AWADDR,
	input  wire        S_AXI_AWVALID,
	output reg         S_AXI_AWREADY,
	input  wire [31:0] S_AXI_WDATA,
	input  wire [3:0]  S_AXI_WSTRB,
	input  wire        S_AXI_WVALID,
	output reg         S_AXI_WREADY,
	output reg  [1:0]  S_AXI_BRESP,
	output reg         S_AXI_BVALID,
	input  wire        S_AXI_BREADY,
	input  wire [7:0]  S_AXI_ARADDR,
	input  wire        S_AXI_ARVALID,
	output reg         S_AXI_ARREADY,
	output reg  [31:0] S_AXI_RDATA,
	output reg  [1:0]  S_AXI_RRESP,
	output reg         S_AXI_RVALID,
	input  wire        S_AXI_RREADY,
	input  wire [25:0] PIN_IN,
	output reg  [25:0] PIN_OUT,
	output reg  [25:0] PIN_OE_N,
	output reg  [25:0] PIN_PULLUP_EN,
	output reg  [25:0] PIN_DIG_BUF_EN,
	output reg         EXT_IRQ_1,
	output reg         EXT_IRQ_2,
	output reg         TIMER2_EXT_CLOCK,
	output reg         TIMER3_EXT_CLOCK,
	output reg         CAPTURE_INPUT_1,
	output reg         CAPTURE_INPUT_2,
	output reg         CFG_MISMATCH_RST
);

	localparam NP = `RMPSEL_NPIN;

	// key sequence states
	localparam KS_IDLE = 2'd0;
	localparam KS_K1   = 2'd1;
	localparam KS_OPEN = 2'd2;

	////////////////////////////////////////////////////////////////////////////////
	// registers

	// four of the input selection registers live here; the rest and the output ones sit elsewhere [RULE8]
	reg [4:0]    ext_irq1_pin_sel_r;
	reg [4:0]    ext_irq2_pin_sel_r;
	reg [4:0]    timer3_clock_pin_sel_r;
	reg [4:0]    timer2_clock_pin_sel_r;
	reg [4:0]    capture2_pin_sel_r;
	reg [4:0]    capture1_pin_sel_r;
	reg [29:0]   shadow_r;
	reg          remap_write_lock_r;
	reg [1:0]    key_state_r;
	reg [NP-1:0] converter_pin_cfg_low_r;
	reg [NP-1:0] converter_pin_cfg_high_r;
	reg [NP-1:0] pin_direction_r;
	reg [NP-1:0] pullup_en_r;
	reg [NP-1:0] latch_r;
	reg [NP-1:0] pin_s1_r;
	reg [NP-1:0] pin_s2_r;
	reg          mismatch_r;
	reg [7:0]    awaddr_r;
	reg          aw_have_r;
	reg [31:0]   wdata_r;
	reg [3:0]    wstrb_r;
	reg          w_have_r;
	reg          sel_upd_r;

	wire [29:0]   sel_all = {ext_irq1_pin_sel_r, ext_irq2_pin_sel_r, timer3_clock_pin_sel_r,
		timer2_clock_pin_sel_r, capture2_pin_sel_r, capture1_pin_sel_r};
	wire [NP-1:0] digital = converter_pin_cfg_low_r & converter_pin_cfg_high_r; // [RULE3] [RULE4]
	wire [NP-1:0] pin_digital_rd = pin_s2_r & digital; // [RULE2]

	// selected pin, or low for 26..31
	function route;
		input [4:0]    sel;
		input [NP-1:0] pins;
		begin
			if (sel <= `RMPSEL_SEL_MAXPIN) begin // [RULE10] [RULE23]
				route = pins[sel];
			end else begin
				route = 1'b0;
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// pin side

	always @(posedge CLK) begin
		// two-stage sync; only stage two feeds logic
		pin_s1_r <= PIN_IN;
		pin_s2_r <= pin_s1_r;
	end

	always @(posedge CLK) begin
		if (!RST_N) begin
			PIN_OUT          <= {NP{1'b0}};
			PIN_OE_N         <= {NP{1'b1}};
			PIN_PULLUP_EN    <= {NP{1'b0}};
			PIN_DIG_BUF_EN   <= {NP{1'b0}};
		end else begin
			PIN_OUT          <= latch_r;
			// analog does not block the driver; contention is software's problem
			PIN_OE_N         <= pin_direction_r; // [RULE5]
			// analog function outranks pull-up on a shared pin
			PIN_PULLUP_EN    <= pullup_en_r & digital; // [RULE7] [RULE6]
			PIN_DIG_BUF_EN   <= digital; // [RULE2]
		end
	end

	// peripheral inputs sit one register behind the synchroniser, so they follow a pin in three edges
	always @(posedge CLK) begin
		if (!RST_N) begin
			EXT_IRQ_1        <= 1'b0;
			EXT_IRQ_2        <= 1'b0;
			TIMER2_EXT_CLOCK <= 1'b0;
			TIMER3_EXT_CLOCK <= 1'b0;
			CAPTURE_INPUT_1  <= 1'b0;
			CAPTURE_INPUT_2  <= 1'b0;
			CFG_MISMATCH_RST <= 1'b0;
		end else begin
			EXT_IRQ_1        <= route(ext_irq1_pin_sel_r, pin_digital_rd);
			EXT_IRQ_2        <= route(ext_irq2_pin_sel_r, pin_digital_rd);
			TIMER2_EXT_CLOCK <= route(timer2_clock_pin_sel_r, pin_digital_rd);
			TIMER3_EXT_CLOCK <= route(timer3_clock_pin_sel_r, pin_digital_rd);
			CAPTURE_INPUT_1  <= route(capture1_pin_sel_r, pin_digital_rd);
			CAPTURE_INPUT_2  <= route(capture2_pin_sel_r, pin_digital_rd);
			CFG_MISMATCH_RST <= mismatch_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// write path

	wire       aw_ok  = aw_have_r | S_AXI_AWVALID;
	wire       w_ok   = w_have_r | S_AXI_WVALID;
	wire       do_wr  = aw_ok & w_ok & ~S_AXI_BVALID;
	wire [7:0] wa     = aw_have_r ? awaddr_r : S_AXI_AWADDR;
	wire [31:0] wd    = w_have_r ? wdata_r : S_AXI_WDATA;
	wire [3:0] ws     = w_have_r ? wstrb_r : S_AXI_WSTRB;
	wire       sel_we = do_wr & ~remap_write_lock_r; // [RULE9] [RULE19]
	wire       lo_we  = ws[0];
	wire       hi_we  = ws[1];

	always @(posedge CLK) begin
		if (!RST_N) begin
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY  <= 1'b0;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_BRESP   <= `RMPSEL_RESP_OKAY;
			aw_have_r     <= 1'b0;
			w_have_r      <= 1'b0;
			awaddr_r      <= 8'h00;
			wdata_r       <= 32'h00000000;
			wstrb_r       <= 4'h0;
		end else begin
			// refuse a new half while a response is pending or that half is already held
			S_AXI_AWREADY <= ~aw_have_r & ~S_AXI_AWREADY & S_AXI_AWVALID & ~S_AXI_BVALID;
			S_AXI_WREADY  <= ~w_have_r & ~S_AXI_WREADY & S_AXI_WVALID & ~S_AXI_BVALID;
			if (S_AXI_AWVALID & S_AXI_AWREADY) begin
				aw_have_r <= 1'b1;
				awaddr_r  <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID & S_AXI_WREADY) begin
				w_have_r <= 1'b1;
				wdata_r  <= S_AXI_WDATA;
				wstrb_r  <= S_AXI_WSTRB;
			end
			if (do_wr & aw_have_r & w_have_r) begin
				aw_have_r    <= 1'b0;
				w_have_r     <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				if (wa > `RMPSEL_OFF_STAT || wa[1:0] != 2'b00) begin
					S_AXI_BRESP <= `RMPSEL_RESP_SLVERR;
				end else begin
					S_AXI_BRESP <= `RMPSEL_RESP_OKAY; // [RULE19]
				end
			end else if (S_AXI_BVALID & S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// commit only once both halves are captured, so the response follows both
	wire commit = do_wr & aw_have_r & w_have_r;

	always @(posedge CLK) begin
		if (!RST_N) begin
			ext_irq1_pin_sel_r       <= `RMPSEL_SEL_RST; // [RULE17]
			ext_irq2_pin_sel_r       <= `RMPSEL_SEL_RST;
			timer3_clock_pin_sel_r   <= `RMPSEL_SEL_RST;
			timer2_clock_pin_sel_r   <= `RMPSEL_SEL_RST;
			capture2_pin_sel_r       <= `RMPSEL_SEL_RST;
			capture1_pin_sel_r       <= `RMPSEL_SEL_RST;
		end else if (commit) begin
			// only 5 bits stored per field, so unimplemented bits drop on write
			if (sel_we & hi_we && wa == `RMPSEL_OFF_IRQ1) begin
				ext_irq1_pin_sel_r <= wd[`RMPSEL_HI_LSB +: 5]; // [RULE11] [RULE18]
			end
			if (sel_we & lo_we && wa == `RMPSEL_OFF_IRQ2) begin
				ext_irq2_pin_sel_r <= wd[`RMPSEL_LO_LSB +: 5]; // [RULE12]
			end
			if (sel_we && wa == `RMPSEL_OFF_TMRCLK) begin
				if (hi_we) begin
					timer3_clock_pin_sel_r <= wd[`RMPSEL_HI_LSB +: 5]; // [RULE13]
				end
				if (lo_we) begin
					timer2_clock_pin_sel_r <= wd[`RMPSEL_LO_LSB +: 5]; // [RULE14]
				end
			end
			if (sel_we && wa == `RMPSEL_OFF_CAPT) begin
				if (hi_we) begin
					capture2_pin_sel_r <= wd[`RMPSEL_HI_LSB +: 5]; // [RULE15]
				end
				if (lo_we) begin
					capture1_pin_sel_r <= wd[`RMPSEL_LO_LSB +: 5]; // [RULE16]
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// lock and unlock sequence

	// the lock guards only the selectors; the key sequence itself is always reachable
	always @(posedge CLK) begin
		if (!RST_N) begin
			remap_write_lock_r <= 1'b0;
			key_state_r        <= KS_IDLE;
		end else if (commit) begin
			if (wa == `RMPSEL_OFF_OSCCTL && lo_we) begin
				// unlock keys, then one write that changes the lock bit
				case (key_state_r)
				KS_IDLE: begin
					key_state_r <= (wd[7:0] == `RMPSEL_KEY1) ? KS_K1 : KS_IDLE; // [RULE20]
				end
				KS_K1: begin
					key_state_r <= (wd[7:0] == `RMPSEL_KEY2) ? KS_OPEN : KS_IDLE;
				end
				KS_OPEN: begin
					remap_write_lock_r <= wd[`RMPSEL_LOCK_BIT];
					key_state_r        <= KS_IDLE;
				end
				default: begin
					key_state_r <= KS_IDLE;
				end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin configuration

	always @(posedge CLK) begin
		if (!RST_N) begin
			converter_pin_cfg_low_r  <= `RMPSEL_ANCFG_RST; // [RULE1]
			converter_pin_cfg_high_r <= `RMPSEL_ANCFG_RST;
			pin_direction_r          <= `RMPSEL_DIR_RST;
			pullup_en_r              <= {NP{1'b0}};
			latch_r                  <= {NP{1'b0}};
		end else if (commit) begin
			if (wa == `RMPSEL_OFF_ANCFG0) begin
				converter_pin_cfg_low_r <= wd[NP-1:0];
			end
			if (wa == `RMPSEL_OFF_ANCFG1) begin
				converter_pin_cfg_high_r <= wd[NP-1:0];
			end
			if (wa == `RMPSEL_OFF_DIR) begin
				pin_direction_r <= wd[NP-1:0]; // [RULE21]
			end
			if (wa == `RMPSEL_OFF_PULLUP) begin
				pullup_en_r <= wd[NP-1:0];
			end
			if (wa == `RMPSEL_OFF_LATCH) begin
				latch_r <= wd[NP-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// shadow monitor

	// shadow copies the selectors every edge; a change not after a legal write means the selectors were disturbed
	always @(posedge CLK) begin
		if (!RST_N) begin
			shadow_r   <= 30'h3FFFFFFF;
			sel_upd_r  <= 1'b0;
			mismatch_r <= 1'b0;
		end else begin
			shadow_r   <= sel_all;
			// a legal write shows up in the selectors one edge after its commit
			sel_upd_r  <= commit & sel_we;
			if (!sel_upd_r) begin
				mismatch_r <= mismatch_r | (shadow_r != sel_all); // [RULE22]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read path

	reg [31:0] rd_val;

	always @* begin
		rd_val = 32'h00000000; // [RULE18]
		if (S_AXI_ARADDR == `RMPSEL_OFF_IRQ1) begin
			rd_val[12:8] = ext_irq1_pin_sel_r;
		end else if (S_AXI_ARADDR == `RMPSEL_OFF_IRQ2) begin
			rd_val[4:0] = ext_irq2_pin_sel_r;
		end else if (S_AXI_ARADDR == `RMPSEL_OFF_TMRCLK) begin
			rd_val[12:0] = {timer3_clock_pin_sel_r, 3'b000, timer2_clock_pin_sel_r};
		end else if (S_AXI_ARADDR == `RMPSEL_OFF_CAPT) begin
			rd_val[12:0] = {capture2_pin_sel_r, 3'b000, capture1_pin_sel_r};
		end else if (S_AXI_ARADDR == `RMPSEL_OFF_OSCCTL) begin
			rd_val[`RMPSEL_LOCK_BIT] = remap_write_lock_r;
		end else if (S_AXI_ARADDR == `RMPSEL_OFF_ANCFG0) begin
			rd_val[NP-1:0] = converter_pin_cfg_low_r;
		end else if (S_AXI_ARADDR == `RMPSEL_OFF_ANCFG1) begin
			rd_val[NP-1:0] = converter_pin_cfg_high_r;
		end else if (S_AXI_ARADDR == `RMPSEL_OFF_DIR) begin
			rd_val[NP-1:0] = pin_direction_r;
		end else if (S_AXI_ARADDR == `RMPSEL_OFF_PULLUP) begin
			rd_val[NP-1:0] = pullup_en_r;
		end else if (S_AXI_ARADDR == `RMPSEL_OFF_LATCH) begin
			rd_val[NP-1:0] = latch_r;
		end else if (S_AXI_ARADDR == `RMPSEL_OFF_PINRD) begin
			rd_val[NP-1:0] = pin_digital_rd; // [RULE2]
		end else if (S_AXI_ARADDR == `RMPSEL_OFF_STAT) begin
			rd_val[1:0] = {key_state_r == KS_OPEN, mismatch_r};
		end
	end

	wire rd_bad = (S_AXI_ARADDR > `RMPSEL_OFF_STAT) || (S_AXI_ARADDR[1:0] != 2'b00);

	always @(posedge CLK) begin
		if (!RST_N) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= 32'h00000000;
			S_AXI_RRESP   <= `RMPSEL_RESP_OKAY;
		end else begin
			S_AXI_ARREADY <= S_AXI_ARVALID & ~S_AXI_ARREADY & ~S_AXI_RVALID;
			if (S_AXI_ARVALID & S_AXI_ARREADY) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA  <= rd_val;
				S_AXI_RRESP  <= rd_bad ? `RMPSEL_RESP_SLVERR : `RMPSEL_RESP_OKAY;
			end else if (S_AXI_RVALID & S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end

endmodule
